// [rtl/rts_pkg.sv]
/*
 * shared constants, state and carrier types of the reset time-out sequencer.
 * assumes a single 10 MHz system clock and 8-bit software registers.
 */
package rts_pkg;
  // clock and time-outs
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned POWER_UP_TIMER_MS = 64;
  localparam int unsigned POWER_UP_TIMER_CYCLES_DEF = POWER_UP_TIMER_MS * (CLK_HZ / 1000);
  localparam int unsigned OST_CYCLES = 1024;
  localparam int unsigned POWER_UP_TIMER_CW = 20;
  localparam int unsigned OST_CW = 11;

  // register offsets
  localparam logic [7:0] ADDR_CORE_STATUS = 8'h03;
  localparam logic [7:0] ADDR_CAUSE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h11;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h12;

  // field positions
  localparam int unsigned CAUSE_BOR_BIT = 0;
  localparam int unsigned CAUSE_POR_BIT = 1;
  localparam int unsigned STAT_TO_BIT = 4;
  localparam int unsigned STAT_PD_BIT = 3;
  localparam int unsigned IRQ_N = 5;
  localparam int unsigned EV_POR = 0;
  localparam int unsigned EV_BOR = 1;
  localparam int unsigned EV_WDT = 2;
  localparam int unsigned EV_PIN = 3;
  localparam int unsigned EV_WAKE = 4;

  // reset values
  localparam logic [2:0] STAT_HI_RST = 3'h0;
  localparam logic [2:0] STAT_LO_RST = 3'h0;
  localparam logic [7:0] PC_LOW_RST = 8'h00;
  localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 5'h00;

  // brown-out enable field codes
  localparam logic [1:0] BOE_ALWAYS = 2'h3;
  localparam logic [1:0] BOE_NO_SLEEP = 2'h2;

  typedef enum logic [2:0] {
    ST_POR, ST_POWER_UP_TIMER, ST_OST, ST_PIN, ST_RUN, ST_SLEEP, ST_WAKE
  } rts_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rts_bus_req_s;

  typedef struct packed {
    logic por_flag;
    logic bor_flag;
    logic to_flag;
    logic pd_flag;
  } rts_cause_s;
endpackage

// [rtl/rts_timer.sv]
/*
 * down counter for one time-out stage: loads while start is high, counts ticks.
 * assumes ticks are one-cycle pulses synchronous to clk_in.
 */
`timescale 1ns/1ps
module rts_timer #(
  parameter int unsigned CW = 11,
  parameter int unsigned COUNT = 1024
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // control
  input wire logic start_in,
  input wire logic tick_in,
  // status
  output logic done_out
);
  if (COUNT < 1 || COUNT >= (64'd1 << CW)) begin : g_bad_count
    $error("rts_timer: COUNT does not fit CW");
  end

  logic [CW-1:0] cnt_q;

  // reload while held, then count every tick down to zero
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= '1;
    end else if (start_in) begin
      cnt_q <= CW'(COUNT);
    end else if (tick_in && cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  assign done_out = (cnt_q == '0) && !start_in;
endmodule // rts_timer

// [rtl/rts_irq.sv]
/*
 * sticky event status with write-one-to-clear and a mask onto one level interrupt.
 * assumes events are one-cycle pulses; a set in the clearing cycle wins.
 */
`timescale 1ns/1ps
module rts_irq #(
  parameter int unsigned N = 5
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // events and software access
  input wire logic [N-1:0] event_in,
  input wire logic [N-1:0] clear_in,
  input wire logic [N-1:0] mask_in,
  // results
  output logic [N-1:0] status_out,
  output logic irq_out
);
  if (N < 1 || N > 8) begin : g_bad_n
    $error("rts_irq: N must be 1..8");
  end

  logic [N-1:0] status_q;

  // set beats clear so an event never slips through
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clear_in) | event_in;
    end
  end

  assign status_out = status_q;
  assign irq_out = |(status_q & mask_in);
endmodule // rts_irq

// [rtl/rts_sequencer.sv]
/*
 * reset time-out sequencer and reset-cause recorder for a small 8-bit core.
 * assumes all inputs synchronous to clk_in; arst_n_in is the power-on reset.
 */
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module rts_sequencer #(
  parameter int unsigned POWER_UP_TIMER_CYCLES = rts_pkg::POWER_UP_TIMER_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // analog detectors and pin
  input wire logic por_pulse_in,
  input wire logic brown_out_in,
  input wire logic external_reset_pin_n_in,
  input wire logic external_reset_pin_en_in,
  // configuration
  input wire logic power_up_timer_disable_in,
  input wire logic external_clock_mode_in,
  input wire logic [1:0] brown_out_enable_field_in,
  // oscillator and core events
  input wire logic osc_tick_in,
  input wire logic watchdog_timer_expired_in,
  input wire logic sleep_in,
  input wire logic wake_irq_in,
  input wire logic [7:0] pc_in,
  // register port
  input wire rts_pkg::rts_bus_req_s bus_in,
  output logic [7:0] rdata_out,
  // core control
  output logic core_reset_out,
  output logic core_sleep_out,
  output logic [7:0] program_counter_low_out,
  output logic pc_load_out,
  output logic program_counter_latch_high_clear_out,
  output logic [7:0] core_status_out,
  output logic irq_out
);
  if (POWER_UP_TIMER_CYCLES < 1 || POWER_UP_TIMER_CYCLES >= (64'd1 << rts_pkg::POWER_UP_TIMER_CW)) begin : g_bad_power_up_timer
    $error("rts_sequencer: POWER_UP_TIMER_CYCLES out of range");
  end

  rts_pkg::rts_state_e state_q, state_d;
  rts_pkg::rts_cause_s cause_q;
  logic [2:0] stat_hi_q, stat_lo_q;
  logic [7:0] pc_low_q, rdata_q;
  logic pc_load_q, latch_clr_q;
  logic [rts_pkg::IRQ_N-1:0] mask_q, irq_status, irq_event, irq_clear;
  logic bo_active, hold_pwr, pin_low, power_up_timer_done, ost_done, need_ost;
  logic ev_bor, ev_wdt_rst, ev_wdt_wake, ev_pin_run, ev_pin_sleep, ev_irq_wake, ev_sleep;
  logic wr_status, wr_cause;

  // address decode, used for reads and writes alike
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // brown-out qualified by the enable field; sleep masks it for code 10
  assign bo_active = brown_out_in && (brown_out_enable_field_in == rts_pkg::BOE_ALWAYS ||
    (brown_out_enable_field_in == rts_pkg::BOE_NO_SLEEP && state_q != rts_pkg::ST_SLEEP));
  assign hold_pwr = por_pulse_in || bo_active;
  assign pin_low = external_reset_pin_en_in && !external_reset_pin_n_in;
  assign need_ost = !external_clock_mode_in;

  // classified events, pin beats watchdog beats sleep and interrupt
  assign ev_bor = bo_active && !por_pulse_in;
  assign ev_pin_run = !hold_pwr && state_q == rts_pkg::ST_RUN && pin_low;
  assign ev_wdt_rst = !hold_pwr && state_q == rts_pkg::ST_RUN && !pin_low && watchdog_timer_expired_in;
  assign ev_sleep = !hold_pwr && state_q == rts_pkg::ST_RUN && !pin_low &&
    !watchdog_timer_expired_in && sleep_in;
  assign ev_pin_sleep = !hold_pwr && state_q == rts_pkg::ST_SLEEP && pin_low;
  assign ev_wdt_wake = !hold_pwr && state_q == rts_pkg::ST_SLEEP && !pin_low && watchdog_timer_expired_in;
  assign ev_irq_wake = !hold_pwr && state_q == rts_pkg::ST_SLEEP && !pin_low &&
    !watchdog_timer_expired_in && wake_irq_in;

  // power-up timer reloads for as long as the detectors hold reset
  rts_timer #(.CW(rts_pkg::POWER_UP_TIMER_CW), .COUNT(POWER_UP_TIMER_CYCLES)) u_power_up_timer (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .start_in(state_q != rts_pkg::ST_POWER_UP_TIMER),
    .tick_in(1'b1),
    .done_out(power_up_timer_done)
  );

  // start-up counter counts oscillator cycles, not system clocks
  rts_timer #(.CW(rts_pkg::OST_CW), .COUNT(rts_pkg::OST_CYCLES)) u_ost (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .start_in(state_q != rts_pkg::ST_OST && state_q != rts_pkg::ST_WAKE),
    .tick_in(osc_tick_in),
    .done_out(ost_done)
  );

  // sequence next state; detectors override everything
  always_comb begin
    state_d = state_q;
    case (state_q)
      rts_pkg::ST_POR: begin
        if (!power_up_timer_disable_in) state_d = rts_pkg::ST_POWER_UP_TIMER;
        else if (need_ost) state_d = rts_pkg::ST_OST;
        else state_d = rts_pkg::ST_PIN;
      end
      rts_pkg::ST_POWER_UP_TIMER: begin
        if (power_up_timer_done) state_d = need_ost ? rts_pkg::ST_OST : rts_pkg::ST_PIN;
      end
      rts_pkg::ST_OST: begin
        if (ost_done) state_d = rts_pkg::ST_PIN;
      end
      rts_pkg::ST_PIN: begin
        if (!pin_low) state_d = rts_pkg::ST_RUN;
      end
      rts_pkg::ST_RUN: begin
        if (ev_pin_run || ev_wdt_rst) state_d = rts_pkg::ST_PIN;
        else if (ev_sleep) state_d = rts_pkg::ST_SLEEP;
      end
      rts_pkg::ST_SLEEP: begin
        if (ev_pin_sleep) state_d = rts_pkg::ST_PIN;
        else if (ev_wdt_wake || ev_irq_wake)
          state_d = need_ost ? rts_pkg::ST_WAKE : rts_pkg::ST_RUN;
      end
      rts_pkg::ST_WAKE: begin
        if (ost_done) state_d = rts_pkg::ST_RUN;
      end
      default: state_d = rts_pkg::ST_POR;
    endcase
    if (hold_pwr) state_d = rts_pkg::ST_POR;
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) state_q <= rts_pkg::ST_POR;
    else state_q <= state_d;
  end

  assign wr_status = bus_in.wr && hit(bus_in.addr, rts_pkg::ADDR_CORE_STATUS);
  assign wr_cause = bus_in.wr && hit(bus_in.addr, rts_pkg::ADDR_CAUSE);

  // cause flags: hardware events win over a software write in the same cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cause_q <= '{por_flag: 1'b0, bor_flag: 1'b0, to_flag: 1'b1, pd_flag: 1'b1};
    end else begin
      if (wr_cause) begin
        cause_q.por_flag <= bus_in.wdata[rts_pkg::CAUSE_POR_BIT];
        cause_q.bor_flag <= bus_in.wdata[rts_pkg::CAUSE_BOR_BIT];
      end
      if (por_pulse_in) begin
        cause_q.por_flag <= 1'b0;
        cause_q.to_flag <= 1'b1;
        cause_q.pd_flag <= 1'b1;
      end else if (ev_bor) begin
        cause_q.bor_flag <= 1'b0;
        cause_q.to_flag <= 1'b1;
        cause_q.pd_flag <= 1'b1;
      end else if (ev_wdt_rst) begin
        cause_q.to_flag <= 1'b0;
      end else if (ev_wdt_wake) begin
        cause_q.to_flag <= 1'b0;
        cause_q.pd_flag <= 1'b0;
      end else if (ev_pin_sleep || ev_irq_wake || ev_sleep) begin
        cause_q.to_flag <= 1'b1;
        cause_q.pd_flag <= 1'b0;
      end
    end
  end

  // writable status bits; resets clear the upper three
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stat_hi_q <= rts_pkg::STAT_HI_RST;
      stat_lo_q <= rts_pkg::STAT_LO_RST;
    end else if (hold_pwr || ev_pin_run || ev_pin_sleep || ev_wdt_rst) begin
      stat_hi_q <= rts_pkg::STAT_HI_RST;
    end else if (wr_status) begin
      stat_hi_q <= bus_in.wdata[7:5];
      stat_lo_q <= bus_in.wdata[2:0];
    end
  end

  // program counter load: zero on resets, pc plus one on wake
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pc_low_q <= rts_pkg::PC_LOW_RST;
      pc_load_q <= 1'b1;
      latch_clr_q <= 1'b1;
    end else begin
      pc_load_q <= 1'b0;
      latch_clr_q <= 1'b0;
      if (hold_pwr || ev_pin_run || ev_pin_sleep || ev_wdt_rst) begin
        pc_low_q <= rts_pkg::PC_LOW_RST;
        pc_load_q <= 1'b1;
        latch_clr_q <= 1'b1;
      end else if (state_d == rts_pkg::ST_RUN &&
                   (state_q == rts_pkg::ST_SLEEP || state_q == rts_pkg::ST_WAKE)) begin
        pc_low_q <= pc_in + 8'h01;
        pc_load_q <= 1'b1;
      end
    end
  end

  assign irq_event = {state_d == rts_pkg::ST_RUN && state_q == rts_pkg::ST_WAKE || ev_irq_wake,
                      ev_pin_run || ev_pin_sleep, ev_wdt_rst || ev_wdt_wake, ev_bor, por_pulse_in};
  assign irq_clear = (bus_in.wr && hit(bus_in.addr, rts_pkg::ADDR_IRQ_STATUS)) ?
    bus_in.wdata[rts_pkg::IRQ_N-1:0] : '0;

  // event status and interrupt gating
  rts_irq #(.N(rts_pkg::IRQ_N)) u_irq (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .event_in(irq_event),
    .clear_in(irq_clear),
    .mask_in(mask_q),
    .status_out(irq_status),
    .irq_out(irq_out)
  );

  // mask register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) mask_q <= rts_pkg::IRQ_MASK_RST;
    else if (bus_in.wr && hit(bus_in.addr, rts_pkg::ADDR_IRQ_MASK))
      mask_q <= bus_in.wdata[rts_pkg::IRQ_N-1:0];
  end

  assign core_status_out = {stat_hi_q, cause_q.to_flag, cause_q.pd_flag, stat_lo_q};

  // read data stand one cycle after the strobe only; unmapped reads zero
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) rdata_q <= 8'h00;
    else if (!bus_in.rd) rdata_q <= 8'h00;
    else if (hit(bus_in.addr, rts_pkg::ADDR_CORE_STATUS)) rdata_q <= core_status_out;
    else if (hit(bus_in.addr, rts_pkg::ADDR_CAUSE)) rdata_q <= {6'h00, cause_q.por_flag, cause_q.bor_flag};
    else if (hit(bus_in.addr, rts_pkg::ADDR_IRQ_STATUS)) rdata_q <= {3'h0, irq_status};
    else if (hit(bus_in.addr, rts_pkg::ADDR_IRQ_MASK)) rdata_q <= {3'h0, mask_q};
    else rdata_q <= 8'h00;
  end

  assign rdata_out = rdata_q;
  // reset covers every stage before the core may run, except the wake count, which holds core_sleep_out
  assign core_reset_out = state_q == rts_pkg::ST_POR || state_q == rts_pkg::ST_POWER_UP_TIMER ||
    state_q == rts_pkg::ST_OST || state_q == rts_pkg::ST_PIN;
  assign core_sleep_out = state_q == rts_pkg::ST_SLEEP || state_q == rts_pkg::ST_WAKE;
  assign program_counter_low_out = pc_low_q;
  assign pc_load_out = pc_load_q;
  assign program_counter_latch_high_clear_out = latch_clr_q;

  // helper: oscillator ticks seen in the start-up stage
  logic [11:0] ost_seen_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) ost_seen_q <= 12'h000;
    else if (state_q != rts_pkg::ST_OST && state_q != rts_pkg::ST_WAKE) ost_seen_q <= 12'h000;
    else if (osc_tick_in) ost_seen_q <= ost_seen_q + 12'h001;
  end

  property p_power_up_timer_after_por;
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == rts_pkg::ST_POWER_UP_TIMER && $past(state_q) != rts_pkg::ST_POWER_UP_TIMER) |->
      $past(state_q) == rts_pkg::ST_POR && !$past(hold_pwr);
  endproperty
  a_power_up_timer_after_por: assert property (p_power_up_timer_after_por) else $error("timer began early");

  property p_no_timeout;
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == rts_pkg::ST_POR && !hold_pwr && external_clock_mode_in && power_up_timer_disable_in)
      |=> state_q == rts_pkg::ST_PIN || hold_pwr;
  endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("unexpected time-out");

  property p_pin_release;
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == rts_pkg::ST_PIN && !pin_low && !hold_pwr) |=> !core_reset_out;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("late start after pin");

  property p_ost_len;
    @(posedge clk_in) disable iff (!arst_n_in)
    ($past(state_q) == rts_pkg::ST_OST && state_q == rts_pkg::ST_PIN) |->
      $past(ost_seen_q) == 12'(rts_pkg::OST_CYCLES);
  endproperty
  a_ost_len: assert property (p_ost_len) else $error("start-up count wrong");

  property p_bor_flag;
    @(posedge clk_in) disable iff (!arst_n_in)
    ev_bor |=> !cause_q.bor_flag && cause_q.to_flag && cause_q.pd_flag;
  endproperty
  a_bor_flag: assert property (p_bor_flag) else $error("brown-out flags wrong");

  property p_por_flag_kept;
    @(posedge clk_in) disable iff (!arst_n_in)
    (!por_pulse_in && !wr_cause) |=> cause_q.por_flag == $past(cause_q.por_flag);
  endproperty
  a_por_flag_kept: assert property (p_por_flag_kept) else $error("power-on flag moved");

  property p_wdt_wake;
    @(posedge clk_in) disable iff (!arst_n_in)
    ev_wdt_wake |=> !cause_q.to_flag && !cause_q.pd_flag ##1 !core_reset_out;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake flags wrong");

  property p_pc_zero;
    @(posedge clk_in) disable iff (!arst_n_in)
    hold_pwr |=> program_counter_low_out == 8'h00 && pc_load_out && program_counter_latch_high_clear_out;
  endproperty
  a_pc_zero: assert property (p_pc_zero) else $error("pc not cleared");

  property p_power_up_timer_restart;
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == rts_pkg::ST_POWER_UP_TIMER && bo_active) |=> state_q == rts_pkg::ST_POR && core_reset_out;
  endproperty
  a_power_up_timer_restart: assert property (p_power_up_timer_restart) else $error("timer not restarted");

  property p_hold_pin;
    @(posedge clk_in) disable iff (!arst_n_in)
    (pin_low && state_q != rts_pkg::ST_WAKE) |=> core_reset_out;
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("released with pin low");

  c_power_up: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    state_q == rts_pkg::ST_OST ##1 state_q == rts_pkg::ST_PIN);
  c_sleep_wake: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    state_q == rts_pkg::ST_WAKE ##1 state_q == rts_pkg::ST_RUN);
  c_brown_out: cover property (@(posedge clk_in) disable iff (!arst_n_in) ev_bor);
  c_wdt_reset: cover property (@(posedge clk_in) disable iff (!arst_n_in) ev_wdt_rst);
endmodule // rts_sequencer

// [tb/rts_sequencer_bench.sv]
/* bench for the reset time-out sequencer: power-up, brown-out, pin, watchdog, sleep,
   register and interrupt scenarios, judged at the ports.
   assumes rts_pkg and rts_sequencer compiled first; the assertions live in the design. */
`timescale 1ns/1ps
module rts_sequencer_bench;
  localparam int unsigned POWER_UP_TIMER = 20; // short power-up delay keeps the run brief
  localparam int unsigned OSCILLATOR_STARTUP_COUNTER = rts_pkg::OST_CYCLES;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic por_p = 1'b1;
  logic bo = 1'b0;
  logic pin_n = 1'b1;
  logic pin_en = 1'b1;
  logic power_up_timer_dis = 1'b0;
  logic ext = 1'b1;
  logic [1:0] boe = 2'h3;
  logic tick = 1'b1;
  logic [2:0] ev = 3'h0; // {wake irq, sleep, watchdog}
  logic [7:0] pc = 8'h00;
  rts_pkg::rts_bus_req_s bus = '0;
  logic [7:0] rdata;
  logic [7:0] pc_low;
  logic [7:0] status;
  logic core_reset;
  logic core_sleep;
  logic latch_clr;
  logic pc_load;
  logic irq;
  int bad_count = 0;
  int n_tests = 0;
  int n;
  logic [7:0] d;
  logic irq_a;

  // 10 MHz clock
  always #50 clk_in = ~clk_in;

  rts_sequencer #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER)) dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .por_pulse_in(por_p), .brown_out_in(bo),
    .external_reset_pin_n_in(pin_n), .external_reset_pin_en_in(pin_en),
    .power_up_timer_disable_in(power_up_timer_dis), .external_clock_mode_in(ext),
    .brown_out_enable_field_in(boe), .osc_tick_in(tick), .watchdog_timer_expired_in(ev[0]),
    .sleep_in(ev[1]), .wake_irq_in(ev[2]), .pc_in(pc), .bus_in(bus), .rdata_out(rdata),
    .core_reset_out(core_reset), .core_sleep_out(core_sleep),
    .program_counter_low_out(pc_low), .pc_load_out(pc_load),
    .program_counter_latch_high_clear_out(latch_clr), .core_status_out(status),
    .irq_out(irq)
  );

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // sample a little after the edge so that the edge's own updates have landed
  task automatic settle(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus <= '0;
    #1;
    v = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    logic [7:0] v;
    bus_rd(a, v);
    chk(what, v & m, exp);
  endtask

  task automatic pulse(input logic [2:0] b);
    @(posedge clk_in);
    ev <= b;
    @(posedge clk_in);
    ev <= 3'h0;
  endtask

  // bounded wait for core reset (sel 0) or core sleep (sel 1) to fall
  task automatic wait_low(input int sel, output int k);
    k = 0;
    #1;
    while (((sel == 0) ? core_reset : core_sleep) !== 1'b0 && k < 3000) begin
      @(posedge clk_in);
      #1;
      k++;
    end
  endtask

  task automatic power_on(input logic e, input logic dis, input logic hold, output int k);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    por_p <= 1'b1;
    ext <= e;
    power_up_timer_dis <= dis;
    pin_n <= ~hold;
    settle(16);
    chk("reset core hold", core_reset, 1'b1);
    chk("reset pc low", pc_low, 8'h00);
    chk("reset timeout and power-down", status[4:3], 2'h3);
    chk("reset latch clear", latch_clr, 1'b1);
    chk("reset pc load", pc_load, 1'b1);
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    settle(5);
    chk("power-on pulse holds core", core_reset, 1'b1);
    @(posedge clk_in);
    por_p <= 1'b0;
    if (hold) begin
      settle(POWER_UP_TIMER + 50);
      chk("pin low holds core", core_reset, 1'b1);
      @(posedge clk_in);
      pin_n <= 1'b1;
    end
    wait_low(0, k);
  endtask

  task automatic pin_rst(output int k);
    @(posedge clk_in);
    pin_n <= 1'b0;
    repeat (3) @(posedge clk_in);
    pin_n <= 1'b1;
    wait_low(0, k);
  endtask

  task automatic regs;
    rd_chk("power-on flag", rts_pkg::ADDR_CAUSE, 8'h02, 8'h00);
    bus_wr(rts_pkg::ADDR_CAUSE, 8'h03);
    rd_chk("cause written", rts_pkg::ADDR_CAUSE, 8'hff, 8'h03);
    bus_wr(rts_pkg::ADDR_CORE_STATUS, 8'he7);
    rd_chk("status flags read-only", rts_pkg::ADDR_CORE_STATUS, 8'hff, 8'hff);
    rd_chk("unmapped read", 8'h40, 8'hff, 8'h00);
  endtask

  // three dips, the second inside the power-up delay that the first started, the third with detection off
  task automatic brown_cases;
    @(posedge clk_in);
    bo <= 1'b1;
    repeat (3) @(posedge clk_in);
    bo <= 1'b0;
    repeat (POWER_UP_TIMER / 2) @(posedge clk_in);
    bo <= 1'b1;
    boe <= 2'h2; // field 10 still watches while awake
    repeat (3) @(posedge clk_in);
    bo <= 1'b0;
    wait_low(0, n);
    chk("delay restarted", 16'(n >= POWER_UP_TIMER && n <= POWER_UP_TIMER + 6), 16'h1);
    chk("brown-out pc low", pc_low, 8'h00);
    chk("brown-out status upper bits", status[7:3], 5'h03);
    rd_chk("brown-out cause", rts_pkg::ADDR_CAUSE, 8'h03, 8'h02);
    @(posedge clk_in);
    boe <= 2'h0;
    bo <= 1'b1;
    settle(4);
    chk("detection off ignores dip", core_reset, 1'b0);
    @(posedge clk_in);
    bo <= 1'b0;
    boe <= 2'h3;
  endtask

  task automatic core_events;
    pulse(3'h1);
    settle(1);
    chk("watchdog reset flags", status[4:3], 2'h1);
    wait_low(0, n);
    chk("watchdog reset pc low", pc_low, 8'h00);
    pin_rst(n);
    chk("pin release starts core", 16'(n >= 1 && n <= 3), 16'h1);
    chk("pin reset keeps flags", status[4:3], 2'h1);
    @(posedge clk_in);
    pin_en <= 1'b0;
    pin_n <= 1'b0;
    settle(4);
    chk("disabled pin ignored", core_reset, 1'b0);
    @(posedge clk_in);
    pin_n <= 1'b1;
    pin_en <= 1'b1;
    pulse(3'h2);
    settle(2);
    chk("sleep entered", core_sleep, 1'b1);
    chk("sleep flags", status[4:3], 2'h2);
    pin_rst(n);
    chk("pin reset in sleep flags", status[4:3], 2'h2);
    // field 10 turns detection off only while asleep
    pulse(3'h2);
    @(posedge clk_in);
    boe <= 2'h2;
    bo <= 1'b1;
    pc <= 8'h7e;
    settle(4);
    chk("no brown-out in sleep", core_reset, 1'b0);
    @(posedge clk_in);
    bo <= 1'b0;
    boe <= 2'h3;
    pulse(3'h1);
    settle(4);
    chk("watchdog wake flags", status[4:3], 2'h0);
    chk("watchdog wake resumes", core_sleep, 1'b0);
    chk("watchdog wake pc", pc_low, 8'h7f);
    // interrupt wake on the crystal clock waits for the start-up count; pc wraps
    @(posedge clk_in);
    ext <= 1'b0;
    pc <= 8'hff;
    pulse(3'h2);
    pulse(3'h4);
    wait_low(1, n);
    chk("wake start-up count", 16'(n >= OSCILLATOR_STARTUP_COUNTER && n <= OSCILLATOR_STARTUP_COUNTER + 6), 16'h1);
    chk("wake pc load", pc_load, 1'b1);
    chk("wake keeps latch", latch_clr, 1'b0);
    settle(1);
    chk("interrupt wake pc", pc_low, 8'h00);
    chk("interrupt wake flags", status[4:3], 2'h2);
    chk("interrupt wake no reset", core_reset, 1'b0);
  endtask

  // every event has fired by now; a set mask bit lets its event through
  task automatic irq_case;
    rd_chk("event status", rts_pkg::ADDR_IRQ_STATUS, 8'h1f, 8'h1f);
    bus_wr(rts_pkg::ADDR_IRQ_MASK, 8'h00);
    settle(2);
    irq_a = irq;
    bus_wr(rts_pkg::ADDR_IRQ_MASK, 8'h1f);
    settle(2);
    chk("masked interrupt", irq_a, 1'b0);
    chk("unmasked interrupt", irq, 1'b1);
    rd_chk("mask readback", rts_pkg::ADDR_IRQ_MASK, 8'h1f, 8'h1f);
    bus_wr(rts_pkg::ADDR_IRQ_STATUS, 8'h1f);
    settle(2);
    chk("interrupt after clear", irq, 1'b0);
    rd_chk("status cleared", rts_pkg::ADDR_IRQ_STATUS, 8'h1f, 8'h00);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    power_on(1'b1, 1'b1, 1'b0, n);
    chk("no time-out", 16'(n <= 3), 16'h1);
    power_on(1'b1, 1'b0, 1'b0, n);
    chk("power-up delay only", 16'(n >= POWER_UP_TIMER && n <= POWER_UP_TIMER + 6), 16'h1);
    power_on(1'b0, 1'b1, 1'b0, n);
    chk("start-up count only", 16'(n >= OSCILLATOR_STARTUP_COUNTER && n <= OSCILLATOR_STARTUP_COUNTER + 6), 16'h1);
    power_on(1'b0, 1'b0, 1'b0, n);
    chk("delay then count", 16'(n >= POWER_UP_TIMER + OSCILLATOR_STARTUP_COUNTER && n <= POWER_UP_TIMER + OSCILLATOR_STARTUP_COUNTER + 8), 16'h1);
    power_on(1'b1, 1'b0, 1'b1, n);
    chk("late pin release", 16'(n <= 2), 16'h1);
    regs();
    brown_cases();
    core_events();
    irq_case();
    wrap_up();
  end

  // the scenarios take well under 1 ms of simulated time
  initial begin
    #3_000_000;
    bad_count++;
    wrap_up();
  end
endmodule // rts_sequencer_bench
